// ===== core/vbc_defs.svh
// Offsets, field positions, reset values and timing counts of the band calibration block
`ifndef VBC_DEFS_SVH
`define VBC_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define VBC_OFS_BANK1_WORD_ZERO  8'h00
`define VBC_OFS_BANK1_WORD_TWO   8'h04
`define VBC_OFS_BANK1_WORD_THREE 8'h08
`define VBC_OFS_BANK2_WORD_ZERO  8'h0C
`define VBC_OFS_BANK2_WORD_TWO   8'h10
`define VBC_OFS_BANK2_WORD_THREE 8'h14
`define VBC_OFS_CONFIG_WORD_ONE  8'h18
`define VBC_OFS_CONFIG_WORD_FIVE 8'h1C
`define VBC_OFS_READBACK_ONE     8'h20
`define VBC_OFS_IRQ_STATUS       8'h24
`define VBC_OFS_IRQ_CLEAR        8'h28
`define VBC_OFS_IRQ_ENABLE       8'h2C

// ****************************************
// Field positions
// ****************************************
`define VBC_W0_OSC_SEL   1:0
`define VBC_W0_CAL_EN    2
`define VBC_W0_DIVIDE    4:3
`define VBC_W2_DEF_BAND  6:0
`define VBC_W3_CORE_I    3:0
`define VBC_C1_FULL_DUP  0
`define VBC_C5_BUF1_I    3:0
`define VBC_C5_BUF2_I    7:4
`define VBC_RB_BAND      6:0
`define VBC_RB_FAIL      7
`define VBC_RB_BUSY      8
`define VBC_IRQ_DONE     0
`define VBC_IRQ_FAIL     1

// ****************************************
// Reset values and codes
// ****************************************
`define VBC_RST_OSC_SEL  2'h1
`define VBC_RST_CAL_EN   1'h1
`define VBC_RST_DIVIDE   2'h0
`define VBC_RST_DEF_BAND 7'h40
`define VBC_RST_CORE_I   4'h8
`define VBC_RST_BUF_I    4'h8
`define VBC_DIV_BY1      2'h0
`define VBC_DIV_BY2      2'h1
`define VBC_DIV_BY4      2'h2

// ****************************************
// Calibration length in phase-detector cycles and band count
// ****************************************
`define VBC_CAL_TOTAL_PD 1500
`define VBC_NUM_BANDS    128

`endif

// ===== core/vbc_pkg.sv
// Types shared by the band calibration block
package vbc_pkg;

   // Calibration sequencer states
   typedef enum logic [1:0] {
      VBC_IDLE   = 2'b00,
      VBC_SEARCH = 2'b01,
      VBC_HOLD   = 2'b10
   } vbc_state_e;

   // One programming bank
   typedef struct packed {
      logic [1:0] osc_select;
      logic       cal_enable;
      logic [1:0] output_divide;
      logic [6:0] default_band;
      logic [3:0] core_current;
   } vbc_bank_s;

   // Analog control outputs of the oscillator path
   typedef struct packed {
      logic [6:0] osc_band;
      logic [1:0] osc_select;
      logic [3:0] core_current;
      logic [2:0] div_onehot;
      logic       mixer1_lo_en;
      logic       mixer2_lo_en;
      logic [3:0] buffer1_current;
      logic [3:0] buffer2_current;
      logic       loop_lock_en;
   } vbc_lo_s;

endpackage

// ===== core/vbc_top.sv
// Oscillator band calibration and LO control with an APB register slave
`timescale 1ns/1ps
`include "vbc_defs.svh"

module vbc_top #(
   parameter int CAL_TOTAL_PD = `VBC_CAL_TOTAL_PD,
   parameter int NUM_BANDS    = `VBC_NUM_BANDS
) (
   // Clock and reset
   input  wire logic           mclk,
   input  wire logic           rst,
   // APB slave
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [7:0]     paddr,
   input  wire logic [31:0]    pwdata,
   output logic                pready,
   output logic [31:0]         prdata,
   output logic                pslverr,
   // Device pins and analog status
   input  wire logic           chip_enable_pin,
   input  wire logic           mixer_select_pin,
   input  wire logic           pd_tick,
   input  wire logic           osc_above_target,
   // Analog controls
   output vbc_pkg::vbc_lo_s    lo_ctrl,
   // Interrupt
   output logic                irq
);
   import vbc_pkg::*;

   // ****************************************
   // Derived constants and checks
   // ****************************************
   localparam int BAND_W  = $clog2(NUM_BANDS);
   localparam int STEP_PD = CAL_TOTAL_PD / NUM_BANDS;
   localparam int TOT_W   = $clog2(CAL_TOTAL_PD + 1);

   localparam logic [6:0]       BAND_TOP  = 7'(NUM_BANDS - 1);
   localparam logic [TOT_W-1:0] TOT_LAST  = TOT_W'(CAL_TOTAL_PD - 1);
   localparam logic [3:0]       STEP_LAST = 4'(STEP_PD - 1);

   // Logic holds a 7-bit band and a 4-bit dwell counter
   if (NUM_BANDS != 128 || STEP_PD < 1 || STEP_PD > 16 ||
       STEP_PD * NUM_BANDS > CAL_TOTAL_PD) begin : g_bad_params
      $error("vbc_top: unsupported band count or calibration length");
   end

   // ****************************************
   // Register state
   // ****************************************
   vbc_bank_s   bank_reg [2];             // Programming banks one and two
   vbc_bank_s   bank_next [2];
   logic        full_dup_reg;             // Full duplex configuration bit
   logic        full_dup_next;
   logic [7:0]  buf_i_reg;                // Both buffer current fields
   logic [7:0]  buf_i_next;
   logic [1:0]  irq_stat_reg;             // Sticky event bits
   logic [1:0]  irq_stat_next;
   logic [1:0]  irq_en_reg;               // Interrupt enables
   logic [1:0]  irq_en_next;
   logic        pready_reg;
   logic        pready_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   logic        irq_reg;
   logic        irq_next;

   // ****************************************
   // Calibration state
   // ****************************************
   vbc_state_e       state_reg;           // Sequencer state
   vbc_state_e       state_next;
   logic [6:0]       band_reg;            // Band driven to the oscillator
   logic [6:0]       band_next;
   logic [6:0]       result_reg;          // Last calibration result
   logic [6:0]       result_next;
   logic             fail_reg;            // Last result was an end band
   logic             fail_next;
   logic [TOT_W-1:0] total_reg;           // Cycles since start of selection
   logic [TOT_W-1:0] total_next;
   logic [3:0]       dwell_reg;           // Cycles spent on current band
   logic [3:0]       dwell_next;
   logic             lock_reg;            // Loop locking allowed
   logic             lock_next;
   logic             en_prev_reg;         // Enable pin one cycle ago
   logic             ev_done;             // Calibration finished this cycle
   logic             ev_fail;             // Finished at an end band

   // ****************************************
   // Output state
   // ****************************************
   vbc_lo_s     lo_reg;
   vbc_lo_s     lo_next;

   // Shared decodes
   logic        setup_ph;                 // APB setup cycle
   logic        wr_en;                    // Write completes at this edge
   logic        act_bank;                 // Active bank index
   vbc_bank_s   act;                      // Fields of the active bank

   assign setup_ph = psel & ~penable;
   assign wr_en    = psel & penable & pready_reg & pwrite;
   assign act_bank = mixer_select_pin;
   assign act      = bank_reg[act_bank];

   // ****************************************
   // Register file next values
   // ****************************************
   always_comb begin
      bank_next     = bank_reg;
      full_dup_next = full_dup_reg;
      buf_i_next    = buf_i_reg;
      irq_en_next   = irq_en_reg;
      irq_stat_next = irq_stat_reg;
      pready_next   = setup_ph;
      prdata_next   = 32'h0000_0000;
      pslverr_next  = 1'b0;
      // Read data and error are prepared during setup
      if (setup_ph) begin
         unique case (paddr)
            `VBC_OFS_BANK1_WORD_ZERO, `VBC_OFS_BANK2_WORD_ZERO: begin
               prdata_next[`VBC_W0_OSC_SEL] = bank_reg[paddr[3]].osc_select;
               prdata_next[`VBC_W0_CAL_EN]  = bank_reg[paddr[3]].cal_enable;
               prdata_next[`VBC_W0_DIVIDE]  = bank_reg[paddr[3]].output_divide;
            end
            `VBC_OFS_BANK1_WORD_TWO: prdata_next[`VBC_W2_DEF_BAND] = bank_reg[0].default_band;
            `VBC_OFS_BANK2_WORD_TWO: prdata_next[`VBC_W2_DEF_BAND] = bank_reg[1].default_band;
            `VBC_OFS_BANK1_WORD_THREE: prdata_next[`VBC_W3_CORE_I] = bank_reg[0].core_current;
            `VBC_OFS_BANK2_WORD_THREE: prdata_next[`VBC_W3_CORE_I] = bank_reg[1].core_current;
            `VBC_OFS_CONFIG_WORD_ONE: prdata_next[`VBC_C1_FULL_DUP] = full_dup_reg;
            `VBC_OFS_CONFIG_WORD_FIVE: prdata_next[7:0] = buf_i_reg;
            `VBC_OFS_READBACK_ONE: begin
               prdata_next[`VBC_RB_BAND] = result_reg;
               prdata_next[`VBC_RB_FAIL] = fail_reg;
               prdata_next[`VBC_RB_BUSY] = (state_reg != VBC_IDLE);
            end
            `VBC_OFS_IRQ_STATUS: prdata_next[1:0] = irq_stat_reg;
            `VBC_OFS_IRQ_CLEAR: prdata_next = 32'h0000_0000;
            `VBC_OFS_IRQ_ENABLE: prdata_next[1:0] = irq_en_reg;
            default: pslverr_next = 1'b1;
         endcase
      end
      // Writes take effect at the access edge
      if (wr_en) begin
         unique case (paddr)
            `VBC_OFS_BANK1_WORD_ZERO, `VBC_OFS_BANK2_WORD_ZERO: begin
               bank_next[paddr[3]].osc_select    = pwdata[`VBC_W0_OSC_SEL];
               bank_next[paddr[3]].cal_enable    = pwdata[`VBC_W0_CAL_EN];
               bank_next[paddr[3]].output_divide = pwdata[`VBC_W0_DIVIDE];
            end
            `VBC_OFS_BANK1_WORD_TWO: bank_next[0].default_band = pwdata[`VBC_W2_DEF_BAND];
            `VBC_OFS_BANK2_WORD_TWO: bank_next[1].default_band = pwdata[`VBC_W2_DEF_BAND];
            `VBC_OFS_BANK1_WORD_THREE: bank_next[0].core_current = pwdata[`VBC_W3_CORE_I];
            `VBC_OFS_BANK2_WORD_THREE: bank_next[1].core_current = pwdata[`VBC_W3_CORE_I];
            `VBC_OFS_CONFIG_WORD_ONE: full_dup_next = pwdata[`VBC_C1_FULL_DUP];
            `VBC_OFS_CONFIG_WORD_FIVE: buf_i_next = pwdata[7:0];
            `VBC_OFS_IRQ_CLEAR: irq_stat_next = irq_stat_reg & ~pwdata[1:0];
            `VBC_OFS_IRQ_ENABLE: irq_en_next = pwdata[1:0];
            default: begin
               // Read-only and unmapped words ignore writes
            end
         endcase
      end
      // Events set after the clear, so a coincident event survives
      if (ev_done) begin
         irq_stat_next[`VBC_IRQ_DONE] = 1'b1;
      end
      if (ev_fail) begin
         irq_stat_next[`VBC_IRQ_FAIL] = 1'b1;
      end
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // Register file flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < 2; b++) begin
            bank_reg[b] <= '{osc_select:    `VBC_RST_OSC_SEL,
                             cal_enable:    `VBC_RST_CAL_EN,
                             output_divide: `VBC_RST_DIVIDE,
                             default_band:  `VBC_RST_DEF_BAND,
                             core_current:  `VBC_RST_CORE_I};
         end
         full_dup_reg <= 1'b0;
         buf_i_reg    <= {`VBC_RST_BUF_I, `VBC_RST_BUF_I};
         irq_stat_reg <= 2'h0;
         irq_en_reg   <= 2'h0;
         pready_reg   <= 1'b0;
         prdata_reg   <= 32'h0000_0000;
         pslverr_reg  <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         bank_reg     <= bank_next;
         full_dup_reg <= full_dup_next;
         buf_i_reg    <= buf_i_next;
         irq_stat_reg <= irq_stat_next;
         irq_en_reg   <= irq_en_next;
         pready_reg   <= pready_next;
         prdata_reg   <= prdata_next;
         pslverr_reg  <= pslverr_next;
         irq_reg      <= irq_next;
      end
   end

   // ****************************************
   // Band calibration sequencer
   // ****************************************
   always_comb begin
      state_next  = state_reg;
      band_next   = band_reg;
      result_next = result_reg;
      fail_next   = fail_reg;
      total_next  = total_reg;
      dwell_next  = dwell_reg;
      lock_next   = lock_reg;
      ev_done     = 1'b0;
      ev_fail     = 1'b0;
      unique case (state_reg)
         VBC_IDLE: begin
            // Enable low stops locking until the next rise
            if (!chip_enable_pin) begin
               lock_next = 1'b0;
            end else if (!en_prev_reg) begin
               if (act.cal_enable) begin
                  // Start from no added capacitance, no locking yet
                  state_next = VBC_SEARCH;
                  band_next  = 7'h00;
                  total_next = '0;
                  dwell_next = 4'h0;
                  lock_next  = 1'b0;
               end else begin
                  // Stored band is applied with no search
                  band_next = act.default_band;
                  lock_next = 1'b1;
               end
            end
         end
         VBC_SEARCH: begin
            if (!chip_enable_pin) begin
               state_next = VBC_IDLE;
            end else if (pd_tick) begin
               total_next = total_reg + 1'b1;
               dwell_next = dwell_reg + 1'b1;
               if (dwell_reg == STEP_LAST) begin
                  dwell_next = 4'h0;
                  // Add one more capacitor while still too fast
                  if (osc_above_target && band_reg != BAND_TOP) begin
                     band_next = band_reg + 1'b1;
                  end else begin
                     state_next = VBC_HOLD;
                  end
               end
            end
         end
         VBC_HOLD: begin
            if (!chip_enable_pin) begin
               state_next = VBC_IDLE;
            end else if (pd_tick) begin
               total_next = total_reg + 1'b1;
               // Released at the fixed length, however early the search stopped
               if (total_reg >= TOT_LAST) begin
                  state_next  = VBC_IDLE;
                  result_next = band_reg;
                  fail_next   = (band_reg == BAND_TOP) ||
                                (band_reg == 7'h00);
                  ev_done     = 1'b1;
                  ev_fail     = fail_next;
                  lock_next   = 1'b1;
               end
            end
         end
         default: begin
            state_next = VBC_IDLE;
         end
      endcase
   end

   // Sequencer flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg   <= VBC_IDLE;
         band_reg    <= `VBC_RST_DEF_BAND;
         result_reg  <= 7'h00;
         fail_reg    <= 1'b0;
         total_reg   <= '0;
         dwell_reg   <= 4'h0;
         lock_reg    <= 1'b0;
         en_prev_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         band_reg    <= band_next;
         result_reg  <= result_next;
         fail_reg    <= fail_next;
         total_reg   <= total_next;
         dwell_reg   <= dwell_next;
         lock_reg    <= lock_next;
         en_prev_reg <= chip_enable_pin;
      end
   end

   // ****************************************
   // Analog control outputs
   // ****************************************
   always_comb begin
      lo_next.osc_band        = band_next;
      lo_next.osc_select      = act.osc_select;
      lo_next.core_current    = act.core_current;
      // Divider choice; the unused code falls back to divide by one
      unique case (act.output_divide)
         `VBC_DIV_BY2: lo_next.div_onehot = 3'b010;
         `VBC_DIV_BY4: lo_next.div_onehot = 3'b100;
         default:      lo_next.div_onehot = 3'b001;
      endcase
      // Full duplex feeds both mixers, otherwise the pin decides
      lo_next.mixer1_lo_en    = full_dup_reg | ~mixer_select_pin;
      lo_next.mixer2_lo_en    = full_dup_reg | mixer_select_pin;
      lo_next.buffer1_current = buf_i_reg[`VBC_C5_BUF1_I];
      lo_next.buffer2_current = buf_i_reg[`VBC_C5_BUF2_I];
      lo_next.loop_lock_en    = lock_next;
   end

   // Output flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lo_reg <= '{osc_band:        `VBC_RST_DEF_BAND,
                     osc_select:      `VBC_RST_OSC_SEL,
                     core_current:    `VBC_RST_CORE_I,
                     div_onehot:      3'b001,
                     mixer1_lo_en:    1'b1,
                     mixer2_lo_en:    1'b0,
                     buffer1_current: `VBC_RST_BUF_I,
                     buffer2_current: `VBC_RST_BUF_I,
                     loop_lock_en:    1'b0};
      end else begin
         lo_reg <= lo_next;
      end
   end

   assign lo_ctrl = lo_reg;
   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;
   assign irq     = irq_reg;

endmodule

// ===== bench/vbc_top_props_props.sv
// Checker of APB handshake, LO routing and calibration stepping at the top ports
`timescale 1ns/1ps

module vbc_top_props #(
   parameter int CAL_TOTAL_PD = 1500,
   parameter int NUM_BANDS    = 128
) (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // APB slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // Pins and analog status
   input wire logic              chip_enable_pin,
   input wire logic              mixer_select_pin,
   input wire logic              pd_tick,
   input wire logic              osc_above_target,
   // Analog controls and interrupt
   input wire vbc_pkg::vbc_lo_s  lo_ctrl,
   input wire logic              irq
);
   import vbc_pkg::*;

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Slave answers in the access cycle and for one cycle only
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside access");
   slverr_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // Lock needs the enable pin and falls after it drops
   lock_drop_a: assert property (!chip_enable_pin [*2] |=> !lo_ctrl.loop_lock_en)
      else $error("lock kept after enable low");
   lock_cause_a: assert property ($rose(lo_ctrl.loop_lock_en) |-> $past(chip_enable_pin))
      else $error("lock rose without enable");
   // Mixer pin steers the LO
   route_one_a: assert property (!mixer_select_pin [*2] |=> lo_ctrl.mixer1_lo_en)
      else $error("mixer one not fed");
   route_two_a: assert property (mixer_select_pin [*2] |=> lo_ctrl.mixer2_lo_en)
      else $error("mixer two not fed");
   div_onehot_a: assert property ($onehot(lo_ctrl.div_onehot))
      else $error("divider select not one-hot");
   // Search moves one band at a time
   band_step_a: assert property ($changed(lo_ctrl.osc_band) && !lo_ctrl.loop_lock_en
      && chip_enable_pin && $past(chip_enable_pin, 2)
      |-> lo_ctrl.osc_band == $past(lo_ctrl.osc_band) + 7'h01)
      else $error("band jumped during search");

   // Main scenarios
   cal_done_c: cover property ($rose(lo_ctrl.loop_lock_en));
   slverr_c: cover property (pslverr);
   irq_c: cover property ($rose(irq));
endmodule

bind vbc_top vbc_top_props #(.CAL_TOTAL_PD(CAL_TOTAL_PD), .NUM_BANDS(NUM_BANDS)) i_props (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .chip_enable_pin(chip_enable_pin), .mixer_select_pin(mixer_select_pin),
   .pd_tick(pd_tick), .osc_above_target(osc_above_target), .lo_ctrl(lo_ctrl), .irq(irq));

// ===== bench/vbc_osc_model.sv
// Behavioural model of the oscillator and phase-detector clock facing the block
`timescale 1ns/1ps

module vbc_osc_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Bench controls
   input  wire logic       slow,
   input  wire logic [7:0] target,
   // Band from the block
   input  wire logic [6:0] band,
   // Analog status to the block
   output logic            pd_tick,
   output logic            osc_above_target
);
   logic [1:0] div_reg;  // Phase-detector divider
   logic [1:0] div_next; // Its next value

   // Slow mode ticks every third cycle, fast every second
   always_comb begin
      div_next = (div_reg >= (slow ? 2'h2 : 2'h1)) ? 2'h0 : div_reg + 2'h1;
   end

   // Divider register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_next;
      end
   end

   // One pulse per phase-detector cycle
   assign pd_tick = (div_reg == 2'h0) && !rst;
   // Each added band lowers the frequency until the target band is reached
   assign osc_above_target = {1'b0, band} < target;
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the band calibration and LO control block
`timescale 1ns/1ps

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end

module testbench;
   import vbc_pkg::*;
   localparam int CAL_PD = 256; // Shortened span, two ticks per band step

   // ****************************************
   // Signals
   // ****************************************
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        chip_enable_pin = 1'b0;
   logic        mixer_select_pin = 1'b0;
   logic        pd_tick;
   logic        osc_above_target;
   logic        slow = 1'b0;           // Phase-detector rate of the model
   logic [7:0]  target = 8'h00;        // Band at which the model stops stepping
   vbc_lo_s     lo_ctrl;
   logic        irq;
   int          errors = 0;
   int          total_checks = 0;
   logic [31:0] r;                     // Last read data
   logic        e;                     // Last slave error
   int          n, t, x;
   logic        p;
   logic [1:0]  dv;
   logic [3:0]  c1, c2;
   logic [7:0]  ex;
   int          tl [4] = '{0, 1, 126, 127};
   logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                             8'h24, 8'h28, 8'h2C, 8'h30};
   logic [31:0] rv [12] = '{32'h5, 32'h40, 32'h8, 32'h5, 32'h40, 32'h8, 32'h0, 32'h88,
                             32'h0, 32'h0, 32'h0, 32'h0};

   vbc_top #(.CAL_TOTAL_PD(CAL_PD)) i_dut (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .chip_enable_pin(chip_enable_pin), .mixer_select_pin(mixer_select_pin),
      .pd_tick(pd_tick), .osc_above_target(osc_above_target), .lo_ctrl(lo_ctrl), .irq(irq));

   vbc_osc_model i_osc (
      .mclk(mclk), .rst(rst), .slow(slow), .target(target), .band(lo_ctrl.osc_band),
      .pd_tick(pd_tick), .osc_above_target(osc_above_target));

   // 20 MHz clock
   always #25 mclk = ~mclk;

   // Expected readback: fail flag above band number
   function automatic logic [7:0] exp_rb(input int v);
      return {(v == 0 || v == 127), 7'(v)};
   endfunction

   // One APB transfer; read data and error land in r and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Wait ends when pready rises; the watchdog ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      `CHK(pready, 1'b1)
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // Verdict and end of run
   task automatic results();
      $display("Checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      x = $urandom(32'h840de55e);
      repeat (16) @(posedge mclk);
      `CHK(lo_ctrl, vbc_lo_s'({7'h40, 2'h1, 4'h8, 3'b001, 2'b10, 8'h88, 1'b0}))
      rst <= 1'b0;
      @(posedge mclk);
      // Reset values, unmapped address, read-only status
      for (int i = 0; i < 12; i++) begin
         apb(1'b0, ra[i], 32'h0);
         `CHK({e, r}, {ra[i] == 8'h30, rv[i]})
      end
      apb(1'b1, 8'h24, 32'hFFFF);
      apb(1'b0, 8'h24, 32'h0);
      `CHK(r, 32'h0)
      // Routing and per-bank currents
      c1 = 4'($urandom);
      c2 = 4'($urandom);
      apb(1'b1, 8'h08, {28'h0, c1});
      apb(1'b1, 8'h14, {28'h0, c2});
      apb(1'b1, 8'h1C, 32'hCC);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 8'h18, {31'h0, i[1]});
         mixer_select_pin <= i[0];
         repeat (3) @(posedge mclk);
         `CHK(lo_ctrl.mixer1_lo_en, i[1] | !i[0])
         `CHK(lo_ctrl.mixer2_lo_en, i[1] | i[0])
         `CHK(lo_ctrl.core_current, i[0] ? c2 : c1)
      end
      `CHK({lo_ctrl.buffer2_current, lo_ctrl.buffer1_current}, 8'hCC)
      apb(1'b1, 8'h18, 32'h0);
      // Calibration runs: band ends, random targets, both banks, masked irq
      for (int i = 0; i < 8; i++) begin
         t = (i < 4) ? tl[i] : 1 + $urandom % 126;
         dv = 2'($urandom % 3);
         p = 1'($urandom);
         mixer_select_pin <= p;
         apb(1'b1, p ? 8'h0C : 8'h00, {27'h0, dv, 1'b1, 2'h1});
         apb(1'b1, 8'h2C, {30'h0, i[0], i[0]});
         target <= 8'(t);
         slow <= i[1];
         chip_enable_pin <= 1'b1;
         n = 0;
         while (lo_ctrl.loop_lock_en !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
         end
         ex = exp_rb(t);
         `CHK((n >= 2 * CAL_PD - 4) && (n <= 3 * CAL_PD + 8), 1'b1)
         `CHK(lo_ctrl.osc_band, ex[6:0])
         `CHK(lo_ctrl.div_onehot, 3'b001 << dv)
         apb(1'b0, 8'h20, 32'h0);
         `CHK(r[8:0], {1'b0, ex})
         apb(1'b0, 8'h24, 32'h0);
         `CHK(r[1:0], {ex[7], 1'b1})
         `CHK(irq, i[0])
         apb(1'b1, 8'h28, 32'h3);
         apb(1'b0, 8'h24, 32'h0);
         `CHK({irq, r[1:0]}, 3'b000)
         chip_enable_pin <= 1'b0;
         repeat (3) @(posedge mclk);
         `CHK(lo_ctrl.loop_lock_en, 1'b0)
      end
      // Enable dropped mid-search leaves no result
      mixer_select_pin <= 1'b0;
      apb(1'b1, 8'h00, 32'h5);
      chip_enable_pin <= 1'b1;
      repeat (100) @(posedge mclk);
      apb(1'b0, 8'h20, 32'h0);
      `CHK(r[8], 1'b1)
      chip_enable_pin <= 1'b0;
      repeat (3 * CAL_PD) @(posedge mclk);
      apb(1'b0, 8'h24, 32'h0);
      `CHK(r[1:0], 2'b00)
      // Fast start from the stored band
      apb(1'b1, 8'h04, 32'(t));
      apb(1'b1, 8'h00, 32'h19);
      chip_enable_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHK({lo_ctrl.loop_lock_en, lo_ctrl.osc_band}, {1'b1, 7'(t)})
      `CHK({lo_ctrl.div_onehot, lo_ctrl.osc_select}, 5'b001_01)
      chip_enable_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      results();
   end

   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge mclk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end
endmodule
